// File: rtl/pss_pkg.sv
// package: shared constants and types for the power source selector
package pss_pkg;
   localparam int unsigned CLK_MHZ       = 200;
   // break-before-make dead time in ns, converted to cycles below
   localparam int unsigned DEAD_NS       = 100;
   localparam int unsigned DEAD_CYC      = (DEAD_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SYNC_STAGES   = 2;
   localparam bit          VARIANT_FIRST = 1'b0;
   localparam bit          VARIANT_SECOND = 1'b1;
   localparam logic        SW_ON         = 1'b0;
   localparam logic        SW_OFF        = 1'b1;

   typedef enum logic [2:0] {
      PSS_ADAPTER   = 3'b000,
      PSS_BRK_TO_BAT = 3'b001,
      PSS_BATTERY   = 3'b011,
      PSS_BRK_TO_AC = 3'b010
   } pss_state_e;
endpackage

// File: rtl/pss_if.sv
// interface: pins between the selector device and the host controller
`timescale 1ns/1ps
interface pss_if;
   logic adapter_present_out;
   logic alarm_out;
   logic adapter_select_in;
   logic converter_enable;

   modport device (
      output adapter_present_out,
      output alarm_out,
      input  adapter_select_in,
      input  converter_enable
   );
   modport host (
      input  adapter_present_out,
      input  alarm_out,
      output adapter_select_in,
      output converter_enable
   );
endinterface

// File: rtl/pss_device.sv
// selector device: source selection, break-before-make and alarm logic
// Behaviour
// - adapter detect low means adapter lost
// - adapter present output follows adapter detect
// - adapter loss on adapter: switch battery, alarm
// - adapter return: select from select input
// - host holds select low to stay battery
// - battery removed on battery: switch to adapter
// - first variant alarms on switch state mismatch
// - charging suspended while battery selected
// - select low keeps battery; high reselects adapter
// - adapter off before battery on
// - load sense blocks battery if adapter shorted
// - alarm high while battery below depletion level
// - first variant stays on source when depleted
// - first variant: deep discharge reverts to adapter
// - second variant: depletion reverts to adapter
// - reinsertion: variant-specific source choice
// - adapter selection needs present, plus select high or an override rule
// - host drops converter enable on adapter loss
`timescale 1ns/1ps
module pss_device #(
   parameter bit          VARIANT  = pss_pkg::VARIANT_FIRST,
   parameter int unsigned DEAD_CYC = pss_pkg::DEAD_CYC
) (
   input  wire logic core_clk,
   input  wire logic nrst,
   pss_if.device     hif,
   input  wire logic adapter_detect_in,
   input  wire logic deplete_level_in,
   input  wire logic deep_discharge_in,
   input  wire logic battery_present_in,
   input  wire logic load_voltage_sense,
   input  wire logic sense_enable_in,
   input  wire logic adapter_switch_fb,
   input  wire logic battery_switch_fb,
   output logic      adapter_switch_drive,
   output logic      battery_switch_drive,
   output logic      charge_enable_out
);
   localparam int unsigned NSYNC = 8;
   localparam int unsigned CW    = $clog2(DEAD_CYC + 1);

   if (DEAD_CYC < 1) begin : g_bad_dead
      $error("dead time must be at least one cycle");
   end

   logic [NSYNC-1:0] raw;
   logic [NSYNC-1:0] s1_reg;
   logic [NSYNC-1:0] s2_reg;
   assign raw = {adapter_switch_fb, battery_switch_fb, sense_enable_in,
                 load_voltage_sense, battery_present_in, deep_discharge_in,
                 deplete_level_in, adapter_detect_in};

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s1_reg <= '0;
         s2_reg <= '0;
      end else begin
         s1_reg <= raw;
         s2_reg <= s1_reg;
      end
   end

   // sync stages reset to zero, which is not the idle level of every pin;
   // nothing acts on them until they hold real pin data
   logic [1:0] run_reg;
   logic       run;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         run_reg <= '0;
      else
         run_reg <= {run_reg[0], 1'b1};
   end
   assign run = run_reg[1];

   logic ac_ok, depleted, deep, bat_in, vs_high, vs_en, ac_fb, bat_fb;
   logic sel_sync1_reg, sel_reg;
   assign ac_ok    = s2_reg[0];
   assign depleted = s2_reg[1];
   assign deep     = s2_reg[2];
   assign bat_in   = s2_reg[3];
   assign vs_high  = s2_reg[4];
   assign vs_en    = s2_reg[5];
   assign bat_fb   = s2_reg[6];
   assign ac_fb    = s2_reg[7];

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sel_sync1_reg <= 1'b0;
         sel_reg       <= 1'b0;
      end else begin
         sel_sync1_reg <= hif.adapter_select_in;
         sel_reg       <= sel_sync1_reg;
      end
   end

   // shorted adapter switch: load still high with sense enabled and adapter present
   logic ac_short;
   assign ac_short = vs_en && vs_high && ac_ok;

   // second variant: battery reinserted while adapter present stays off
   logic bat_lock_reg;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         bat_lock_reg <= 1'b0;
      else if (run && VARIANT == pss_pkg::VARIANT_SECOND && !bat_in)
         bat_lock_reg <= 1'b1;
      else if (!ac_ok)
         bat_lock_reg <= 1'b0;
   end

   logic want_ac;
   always_comb begin
      want_ac = sel_reg && ac_ok;
      if (ac_ok && !bat_in)
         want_ac = 1'b1;
      if (ac_ok && bat_lock_reg)
         want_ac = 1'b1;
      if (VARIANT == pss_pkg::VARIANT_FIRST && ac_ok && deep)
         want_ac = 1'b1;
      if (VARIANT == pss_pkg::VARIANT_SECOND && ac_ok && depleted)
         want_ac = 1'b1;
      if (!ac_ok)
         want_ac = 1'b0;
   end

   pss_pkg::pss_state_e st_reg;
   logic [CW-1:0]       cnt_reg;
   logic                auto_bat_reg;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_reg  <= pss_pkg::PSS_ADAPTER;
         cnt_reg <= '0;
      end else begin
         case (st_reg)
            pss_pkg::PSS_ADAPTER: begin
               // manual switch is refused if the adapter switch is shorted
               if (run && !want_ac && (!ac_ok || !ac_short)) begin
                  st_reg  <= pss_pkg::PSS_BRK_TO_BAT;
                  cnt_reg <= CW'(DEAD_CYC);
               end
            end
            pss_pkg::PSS_BRK_TO_BAT: begin
               if (cnt_reg > CW'(1))
                  cnt_reg <= cnt_reg - CW'(1);
               else
                  st_reg <= pss_pkg::PSS_BATTERY;
            end
            pss_pkg::PSS_BATTERY: begin
               if (want_ac) begin
                  st_reg  <= pss_pkg::PSS_BRK_TO_AC;
                  cnt_reg <= CW'(DEAD_CYC);
               end
            end
            pss_pkg::PSS_BRK_TO_AC: begin
               if (cnt_reg > CW'(1))
                  cnt_reg <= cnt_reg - CW'(1);
               else
                  st_reg <= pss_pkg::PSS_ADAPTER;
            end
            default: st_reg <= pss_pkg::PSS_ADAPTER;
         endcase
      end
   end

   // remembers a fail-over caused by adapter loss, for the alarm
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         auto_bat_reg <= 1'b0;
      else if (run && st_reg == pss_pkg::PSS_ADAPTER && !ac_ok)
         auto_bat_reg <= 1'b1;
      else if (ac_ok)
         auto_bat_reg <= 1'b0;
   end

   // adapter switch stays off until a present adapter has been seen once
   logic started_reg;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         started_reg <= 1'b0;
      else if (run && ac_ok)
         started_reg <= 1'b1;
   end

   logic ac_cmd, bat_cmd, mismatch;
   always_comb begin
      ac_cmd  = pss_pkg::SW_OFF;
      bat_cmd = pss_pkg::SW_OFF;
      if (st_reg == pss_pkg::PSS_ADAPTER && started_reg)
         ac_cmd = pss_pkg::SW_ON;
      if (st_reg == pss_pkg::PSS_BATTERY)
         bat_cmd = pss_pkg::SW_ON;
   end
   // feedback passes the input synchroniser, so it is compared with drives
   // of the same age; otherwise each switch change would raise the alarm
   logic [1:0] drv_d1_reg;
   logic [1:0] drv_d2_reg;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         drv_d1_reg <= {2{pss_pkg::SW_OFF}};
         drv_d2_reg <= {2{pss_pkg::SW_OFF}};
      end else begin
         drv_d1_reg <= {adapter_switch_drive, battery_switch_drive};
         drv_d2_reg <= drv_d1_reg;
      end
   end
   // feedback is low when a switch conducts; checked only in steady states
   assign mismatch = run &&
                     (st_reg == pss_pkg::PSS_ADAPTER ||
                      st_reg == pss_pkg::PSS_BATTERY) &&
                     ({ac_fb, bat_fb} != drv_d2_reg);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         adapter_switch_drive    <= pss_pkg::SW_OFF;
         battery_switch_drive    <= pss_pkg::SW_OFF;
         charge_enable_out       <= 1'b0;
         hif.adapter_present_out <= 1'b0;
         hif.alarm_out           <= 1'b0;
      end else begin
         adapter_switch_drive    <= ac_cmd;
         battery_switch_drive    <= bat_cmd;
         charge_enable_out       <= (ac_cmd == pss_pkg::SW_ON);
         hif.adapter_present_out <= ac_ok;
         hif.alarm_out <= depleted || auto_bat_reg
            || (VARIANT == pss_pkg::VARIANT_FIRST && mismatch);
      end
   end
endmodule

// File: rtl/pss_host.sv
// host end: drives adapter select and converter enable
`timescale 1ns/1ps
module pss_host (
   input  wire logic core_clk,
   input  wire logic nrst,
   pss_if.host       dif,
   input  wire logic learn_req,
   input  wire logic charge_req,
   output logic      adapter_present,
   output logic      alarm
);
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dif.adapter_select_in <= 1'b1;
         dif.converter_enable  <= 1'b0;
         adapter_present       <= 1'b0;
         alarm                 <= 1'b0;
      end else begin
         // select low holds battery through a learn cycle
         dif.adapter_select_in <= !learn_req;
         // converter stays off whenever adapter is gone
         dif.converter_enable  <= charge_req && dif.adapter_present_out;
         adapter_present       <= dif.adapter_present_out;
         alarm                 <= dif.alarm_out;
      end
   end
endmodule

// File: verification/pss_chk.sv
// checker: assertions on the selector pins and the host interface
`timescale 1ns/1ps
module pss_chk (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic adapter_present_out,
   input wire logic alarm_out,
   input wire logic adapter_select_in,
   input wire logic converter_enable,
   input wire logic adapter_detect_in,
   input wire logic deplete_level_in,
   input wire logic adapter_switch_drive,
   input wire logic battery_switch_drive,
   input wire logic charge_enable_out
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // drives are low-on, so at least one must stay high
   a_never_both_on: assert property (
      adapter_switch_drive | battery_switch_drive)
      else $error("both switches on");
   a_present_follows: assert property (
      $fell(adapter_detect_in) |-> ##[2:4] !adapter_present_out)
      else $error("present not dropped on detect loss");
   a_loss_alarm: assert property (
      $fell(adapter_present_out) && !adapter_switch_drive
      |-> ##[0:2] alarm_out)
      else $error("no alarm on failover");
   a_gap_to_bat: assert property (
      $fell(battery_switch_drive) |-> $past(adapter_switch_drive, 2))
      else $error("battery on without dead time");
   a_gap_to_ac: assert property (
      $fell(adapter_switch_drive) |-> $past(battery_switch_drive, 2))
      else $error("adapter on without dead time");
   a_deplete_alarm: assert property (
      deplete_level_in [*8] |-> alarm_out)
      else $error("no alarm while depleted");
   a_ac_needs_pres: assert property (
      $fell(adapter_switch_drive) |-> adapter_present_out)
      else $error("adapter selected while absent");
   a_no_charge_bat: assert property (
      !battery_switch_drive |-> !charge_enable_out)
      else $error("charging while on battery");
   a_host_enable: assert property (
      $fell(adapter_present_out) |-> ##[1:4] !converter_enable)
      else $error("converter enable kept after loss");
endmodule

// File: verification/power_source_selector_tb.sv
// testbench: both ends joined, selector scenarios with expected pins
`timescale 1ns/1ps
module power_source_selector_tb;
   logic core_clk = 1'b0;
   logic nrst     = 1'b0;
   logic det = 1'b1, dep = 1'b0, deep = 1'b0, bat = 1'b1, load = 1'b0;
   logic sen = 1'b0, fb_err = 1'b0, learn = 1'b0, chg = 1'b1;
   logic ad_drv, bat_drv, chg_en, pres, alm;
   logic ad2, bat2, chg2, pres2, alm2;
   int   fails = 0;
   int   checked = 0;
   pss_if ifc ();
   pss_if ifc2 ();
   always #2.5 core_clk = ~core_clk;
   pss_device #(.VARIANT(pss_pkg::VARIANT_FIRST), .DEAD_CYC(2)) u_pss_device (
      .core_clk(core_clk), .nrst(nrst), .hif(ifc.device),
      .adapter_detect_in(det), .deplete_level_in(dep),
      .deep_discharge_in(deep), .battery_present_in(bat),
      .load_voltage_sense(load), .sense_enable_in(sen),
      .adapter_switch_fb(ad_drv ^ fb_err), .battery_switch_fb(bat_drv),
      .adapter_switch_drive(ad_drv), .battery_switch_drive(bat_drv),
      .charge_enable_out(chg_en));
   pss_host u_pss_host (
      .core_clk(core_clk), .nrst(nrst), .dif(ifc.host),
      .learn_req(learn), .charge_req(chg),
      .adapter_present(pres), .alarm(alm));
   pss_device #(.VARIANT(pss_pkg::VARIANT_SECOND), .DEAD_CYC(2))
      u_pss_device_v2 (
      .core_clk(core_clk), .nrst(nrst), .hif(ifc2.device),
      .adapter_detect_in(det), .deplete_level_in(dep),
      .deep_discharge_in(deep), .battery_present_in(bat),
      .load_voltage_sense(load), .sense_enable_in(sen),
      .adapter_switch_fb(ad2), .battery_switch_fb(bat2),
      .adapter_switch_drive(ad2), .battery_switch_drive(bat2),
      .charge_enable_out(chg2));
   pss_host u_pss_host_v2 (
      .core_clk(core_clk), .nrst(nrst), .dif(ifc2.host),
      .learn_req(learn), .charge_req(chg),
      .adapter_present(pres2), .alarm(alm2));
   pss_chk u_pss_chk (
      .core_clk(core_clk), .nrst(nrst),
      .adapter_present_out(ifc.adapter_present_out),
      .alarm_out(ifc.alarm_out), .adapter_select_in(ifc.adapter_select_in),
      .converter_enable(ifc.converter_enable), .adapter_detect_in(det),
      .deplete_level_in(dep), .adapter_switch_drive(ad_drv),
      .battery_switch_drive(bat_drv), .charge_enable_out(chg_en));
   task automatic summarize();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // e = {adapter drive, battery drive, present, alarm}; charge follows
   // the adapter switch, host copies follow present and alarm, converter enable follows present
   task automatic look(input string n, input logic [3:0] e,
                       input logic [7:0] got);
      logic [7:0] x;
      x = {e, ~e[3], e[1], e[0], e[1] & chg};
      checked++;
      if (got !== x) begin
         $display("MISMATCH %s exp %h got %h", n, x, got);
         fails++;
      end
   endtask
   // long settle covers synchroniser, dead time and host copy latency
   task automatic step(input string n, input logic [3:0] e,
                       input logic [3:0] e2);
      repeat (40) @(posedge core_clk);
      #1;
      look({n, " v1"}, e, {ad_drv, bat_drv, ifc.adapter_present_out,
           ifc.alarm_out, chg_en, pres, alm, ifc.converter_enable});
      look({n, " v2"}, e2, {ad2, bat2, ifc2.adapter_present_out,
           ifc2.alarm_out, chg2, pres2, alm2, ifc2.converter_enable});
      $display("test %s done", n);
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      #1 nrst = 1'b1;
      step("init", 4'h6, 4'h6);
      det = 1'b0; step("ac_loss", 4'h9, 4'h9);
      det = 1'b1; step("ac_back", 4'h6, 4'h6);
      learn = 1'b1; step("learn", 4'hA, 4'hA);
      learn = 1'b0; step("learn_end", 4'h6, 4'h6);
      learn = 1'b1; step("learn2", 4'hA, 4'hA);
      bat = 1'b0; step("bat_removed", 4'h6, 4'h6);
      bat = 1'b1; sen = 1'b1; load = 1'b1;
      step("short_block", 4'h6, 4'h6);
      sen = 1'b0; step("sense_off", 4'hA, 4'h6);
      learn = 1'b0; load = 1'b0; step("back_ac", 4'h6, 4'h6);
      det = 1'b0; step("ac_loss2", 4'h9, 4'h9);
      det = 1'b1; step("ac_back2", 4'h6, 4'h6);
      dep = 1'b1; step("dep_ac", 4'h7, 4'h7);
      learn = 1'b1; step("dep_bat", 4'hB, 4'h7);
      deep = 1'b1; step("deep", 4'h7, 4'h7);
      deep = 1'b0; dep = 1'b0; learn = 1'b0; step("clear", 4'h6, 4'h6);
      fb_err = 1'b1; step("fb_mismatch", 4'h7, 4'h6);
      fb_err = 1'b0; step("fb_ok", 4'h6, 4'h6);
      summarize();
   end
   initial begin
      #20000;
      fails++;
      summarize();
   end
endmodule
